// file: shared/dae_defines.vh
`ifndef DAE_DEFINES_VH
`define DAE_DEFINES_VH
// ********************************
// register offsets
// ********************************
`define DAE_REG_CTRL 4'h0
`define DAE_REG_A1TYPE 4'h1
`define DAE_REG_A2TYPE 4'h2
`define DAE_REG_A1HYS 4'h3
`define DAE_REG_A2HYS 4'h4
`define DAE_REG_A1VAL 4'h5
`define DAE_REG_A2VAL 4'h6
`define DAE_REG_HBTHR 4'h7
`define DAE_REG_HBHYS 4'h8
`define DAE_REG_STAT 4'h9
`define DAE_REG_IRQ 4'hA
`define DAE_REG_MASK 4'hB
`define DAE_REG_CUR 4'hC
// ********************************
// reset values
// ********************************
`define DAE_A1TYPE_RST 5'h01
`define DAE_A2TYPE_RST 5'h02
`define DAE_HYS_RST 16'h0005
`define DAE_A1VAL_RST 16'h03E8
`define DAE_A2VAL_RST 16'h0000
`define DAE_HBTHR_RST 6'h00
`define DAE_HBHYS_RST 6'h01
// ********************************
// limits and codes
// ********************************
`define DAE_A1_MAX 5'h15
`define DAE_A2_MAX 5'h14
`define DAE_HB_CODE 5'h15
`define DAE_HB_MAX 6'h32
`define DAE_PCT_MAX 16'h03E8
`define DAE_PCT_MIN 16'hFC18
`define DAE_TYPE_OFF 5'h00
`endif

// file: rtl/dae_alarm.v
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dae_defines.vh"
// Behaviour
// - two alarms, own type and hysteresis
// - alarm1 type off or 1-21, default 1
// - alarm2 type off or 1-20, default 2, optional
// - heater break only alarm1 code 21
// - heater break off in current-loop mode
// - heater threshold off or 1-50 A
// - measure heater current, expose, warn
// - hysteresis 0.0-100.0 %, default 0.5 %
// - alarm value -100..100 %, defaults 100/0
// - base codes absolute, deviation, band
// - inverted codes reverse contact sense
// - hold codes 11-20 mapping
// - hold suppresses alarm until first crossing
module dae_alarm #(
  parameter ALARM2_FITTED = 1
) (
  input wire mclk,
  input wire nrst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire signed [15:0] process_value,
  input wire signed [15:0] target_setpoint,
  input wire [5:0] heater_current_sensor,
  input wire current_loop_drive_mode,
  output reg alarm1_lamp_ff,
  output reg alarm1_contact_ff,
  output reg alarm2_lamp_ff,
  output reg alarm2_contact_ff,
  output reg heater_break_alarm_ff,
  output reg irq_ff
);
  // ********************************
  // type decode
  // ********************************
  // base kind: 1 upper abs,2 lower abs,3 upper dev,4 lower dev,7 band out,8 band in
  function [3:0] base_kind;
    input [4:0] c;
    begin
      case (c)
        5'h01, 5'h09, 5'h0B, 5'h13: base_kind = 4'h1;
        5'h02, 5'h0A, 5'h0C, 5'h14: base_kind = 4'h2;
        5'h03, 5'h05, 5'h0D, 5'h0F: base_kind = 4'h3;
        5'h04, 5'h06, 5'h0E, 5'h10: base_kind = 4'h4;
        5'h07, 5'h11: base_kind = 4'h7;
        5'h08, 5'h12: base_kind = 4'h8;
        default: base_kind = 4'h0;
      endcase
    end
  endfunction
  function is_inv;
    input [4:0] c;
    begin
      is_inv = (c == 5'h09) || (c == 5'h0A) || (c == 5'h05) || (c == 5'h06) ||
        (c == 5'h13) || (c == 5'h14) || (c == 5'h0F) || (c == 5'h10);
    end
  endfunction
  function is_hold;
    input [4:0] c;
    begin
      is_hold = (c >= 5'h0B) && (c <= 5'h14);
    end
  endfunction
  // next alarm state with hysteresis; x compared, v threshold
  function eval;
    input [3:0] k;
    input signed [17:0] x;
    input signed [17:0] v;
    input signed [17:0] h;
    input cur;
    reg signed [17:0] av;
    begin
      av = (v < 0) ? -v : v;
      case (k)
        4'h1, 4'h3: eval = cur ? (x > v - h) : (x > v);
        4'h2, 4'h4: eval = cur ? (x < v + h) : (x < v);
        4'h7: eval = cur ? ((x > av - h) || (x < -av + h)) : ((x > av) || (x < -av));
        4'h8: eval = cur ? ((x <= av + h) && (x >= -av - h)) : ((x <= av) && (x >= -av));
        default: eval = 1'b0;
      endcase
    end
  endfunction
  // ********************************
  // registers
  // ********************************
  reg [4:0] a1type_ff;
  reg [4:0] a2type_ff;
  reg [15:0] a1hys_ff;
  reg [15:0] a2hys_ff;
  reg [15:0] a1val_ff;
  reg [15:0] a2val_ff;
  reg [5:0] hbthr_ff;
  reg [5:0] hbhys_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;
  reg a1_act_ff;
  reg a2_act_ff;
  reg a1_armed_ff;
  reg a2_armed_ff;
  reg hb_act_ff;
  reg [5:0] cur_ff;
  // write lands at the edge where the master sees waitrequest low
  wire wr_en = avs_write && !avs_waitrequest;
  wire rd_en = avs_read && avs_waitrequest;
  wire [15:0] wd16 = avs_writedata[15:0];
  wire signed [15:0] wds = avs_writedata[15:0];
  wire in_pct = (wds >= $signed(`DAE_PCT_MIN)) && (wds <= $signed(`DAE_PCT_MAX));
  wire hys_ok = (wd16 <= `DAE_PCT_MAX);
  always @(posedge mclk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      a1type_ff <= `DAE_A1TYPE_RST;
      a2type_ff <= ALARM2_FITTED ? `DAE_A2TYPE_RST : `DAE_TYPE_OFF;
      a1hys_ff <= `DAE_HYS_RST;
      a2hys_ff <= `DAE_HYS_RST;
      a1val_ff <= `DAE_A1VAL_RST;
      a2val_ff <= `DAE_A2VAL_RST;
      hbthr_ff <= `DAE_HBTHR_RST;
      hbhys_ff <= `DAE_HBHYS_RST;
      irq_mask_ff <= 3'h0;
    end else begin
      avs_waitrequest <= !(avs_read || avs_write) || !avs_waitrequest;
      if (wr_en) begin
        if (avs_address == `DAE_REG_A1TYPE) begin
          if (avs_writedata[4:0] <= `DAE_A1_MAX)
            a1type_ff <= avs_writedata[4:0];
        end else if (avs_address == `DAE_REG_A2TYPE) begin
          if (ALARM2_FITTED && avs_writedata[4:0] <= `DAE_A2_MAX)
            a2type_ff <= avs_writedata[4:0];
        end else if (avs_address == `DAE_REG_A1HYS) begin
          if (hys_ok)
            a1hys_ff <= wd16;
        end else if (avs_address == `DAE_REG_A2HYS) begin
          if (hys_ok)
            a2hys_ff <= wd16;
        end else if (avs_address == `DAE_REG_A1VAL) begin
          if (in_pct)
            a1val_ff <= wd16;
        end else if (avs_address == `DAE_REG_A2VAL) begin
          if (in_pct)
            a2val_ff <= wd16;
        end else if (avs_address == `DAE_REG_HBTHR) begin
          if (avs_writedata[5:0] <= `DAE_HB_MAX)
            hbthr_ff <= avs_writedata[5:0];
        end else if (avs_address == `DAE_REG_HBHYS) begin
          if (avs_writedata[5:0] <= `DAE_HB_MAX)
            hbhys_ff <= avs_writedata[5:0];
        end else if (avs_address == `DAE_REG_MASK) begin
          irq_mask_ff <= avs_writedata[2:0];
        end
      end
      if (rd_en) begin
        if (avs_address == `DAE_REG_A1TYPE)
          avs_readdata <= {27'h0000000, a1type_ff};
        else if (avs_address == `DAE_REG_A2TYPE)
          avs_readdata <= {27'h0000000, a2type_ff};
        else if (avs_address == `DAE_REG_A1HYS)
          avs_readdata <= {16'h0000, a1hys_ff};
        else if (avs_address == `DAE_REG_A2HYS)
          avs_readdata <= {16'h0000, a2hys_ff};
        else if (avs_address == `DAE_REG_A1VAL)
          avs_readdata <= {16'h0000, a1val_ff};
        else if (avs_address == `DAE_REG_A2VAL)
          avs_readdata <= {16'h0000, a2val_ff};
        else if (avs_address == `DAE_REG_HBTHR)
          avs_readdata <= {26'h0000000, hbthr_ff};
        else if (avs_address == `DAE_REG_HBHYS)
          avs_readdata <= {26'h0000000, hbhys_ff};
        else if (avs_address == `DAE_REG_STAT)
          avs_readdata <= {25'h0000000, a2_armed_ff, a1_armed_ff, hb_act_ff,
            a2_act_ff, a1_act_ff, 1'b0, current_loop_drive_mode};
        else if (avs_address == `DAE_REG_IRQ)
          avs_readdata <= {29'h00000000, irq_stat_ff};
        else if (avs_address == `DAE_REG_MASK)
          avs_readdata <= {29'h00000000, irq_mask_ff};
        else if (avs_address == `DAE_REG_CUR)
          avs_readdata <= {26'h0000000, cur_ff};
        else
          avs_readdata <= 32'h00000000;
      end
    end
  end
  // ********************************
  // evaluation
  // ********************************
  wire signed [17:0] proc_x = {{2{process_value[15]}}, process_value};
  wire signed [17:0] dev_x = proc_x - {{2{target_setpoint[15]}}, target_setpoint};
  wire [3:0] k1 = base_kind(a1type_ff);
  wire [3:0] k2 = base_kind(a2type_ff);
  wire signed [17:0] x1 = (k1 == 4'h1 || k1 == 4'h2) ? proc_x : dev_x;
  wire signed [17:0] x2 = (k2 == 4'h1 || k2 == 4'h2) ? proc_x : dev_x;
  wire signed [17:0] v1 = {{2{a1val_ff[15]}}, a1val_ff};
  wire signed [17:0] v2 = {{2{a2val_ff[15]}}, a2val_ff};
  wire signed [17:0] h1 = {2'h0, a1hys_ff};
  wire signed [17:0] h2 = {2'h0, a2hys_ff};
  wire raw1 = eval(k1, x1, v1, h1, a1_act_ff);
  wire raw2 = eval(k2, x2, v2, h2, a2_act_ff);
  // armed once the condition has been clear since reset, whatever the type
  wire nxt_a1_armed = a1_armed_ff || !raw1;
  wire nxt_a2_armed = a2_armed_ff || !raw2;
  wire nxt_a1_act = raw1 && (a1_armed_ff || !is_hold(a1type_ff));
  wire nxt_a2_act = raw2 && (a2_armed_ff || !is_hold(a2type_ff)) &&
    (ALARM2_FITTED != 0);
  wire hb_en = (a1type_ff == `DAE_HB_CODE) && (hbthr_ff != `DAE_HBTHR_RST) &&
    !current_loop_drive_mode;
  wire [6:0] hb_rel = {1'b0, hbthr_ff} + {1'b0, hbhys_ff};
  wire nxt_hb_act = hb_en && (hb_act_ff ? ({1'b0, cur_ff} < hb_rel) :
    (cur_ff < hbthr_ff));
  wire [2:0] ev = {nxt_hb_act & ~hb_act_ff, nxt_a2_act & ~a2_act_ff, nxt_a1_act & ~a1_act_ff};
  wire [2:0] clr = (wr_en && avs_address == `DAE_REG_IRQ) ? avs_writedata[2:0] : 3'h0;
  always @(posedge mclk) begin
    if (!nrst) begin
      a1_act_ff <= 1'b0;
      a2_act_ff <= 1'b0;
      a1_armed_ff <= 1'b0;
      a2_armed_ff <= 1'b0;
      hb_act_ff <= 1'b0;
      cur_ff <= 6'h00;
      irq_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
      alarm1_lamp_ff <= 1'b0;
      alarm1_contact_ff <= 1'b0;
      alarm2_lamp_ff <= 1'b0;
      alarm2_contact_ff <= 1'b0;
      heater_break_alarm_ff <= 1'b0;
    end else begin
      cur_ff <= heater_current_sensor;
      a1_armed_ff <= nxt_a1_armed;
      a2_armed_ff <= nxt_a2_armed;
      a1_act_ff <= nxt_a1_act;
      a2_act_ff <= nxt_a2_act;
      hb_act_ff <= nxt_hb_act;
      irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
      irq_ff <= |(((irq_stat_ff & ~clr) | ev) & irq_mask_ff);
      alarm1_lamp_ff <= (a1type_ff == `DAE_HB_CODE) ? nxt_hb_act : nxt_a1_act;
      alarm1_contact_ff <= (a1type_ff == `DAE_HB_CODE) ? nxt_hb_act :
        (is_inv(a1type_ff) ? !nxt_a1_act : nxt_a1_act);
      alarm2_lamp_ff <= nxt_a2_act;
      alarm2_contact_ff <= (a2type_ff == `DAE_TYPE_OFF) ? 1'b0 :
        (is_inv(a2type_ff) ? !nxt_a2_act : nxt_a2_act);
      heater_break_alarm_ff <= nxt_hb_act;
    end
  end
endmodule // dae_alarm
`default_nettype wire

// file: sim/dae_alarm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dae_alarm_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic signed [15:0] process_value,
  input wire logic signed [15:0] target_setpoint,
  input wire logic [5:0] heater_current_sensor,
  input wire logic current_loop_drive_mode,
  input wire logic alarm1_lamp_ff,
  input wire logic alarm2_lamp_ff,
  input wire logic alarm2_contact_ff,
  input wire logic heater_break_alarm_ff,
  input wire logic irq_ff
);
  // ********************
  // bus and alarm checks
  // ********************
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire req = avs_read || avs_write;
  chk_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_idle: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("readdata moved without read");
  chk_hb_mode: assert property (
    current_loop_drive_mode && $past(current_loop_drive_mode) |-> !heater_break_alarm_ff)
    else $error("heater break in current loop mode");
  chk_hb_rise: assert property (
    $rose(heater_break_alarm_ff) |-> $past(heater_current_sensor, 2) < 6'h32)
    else $error("heater break above max threshold");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !nrst |=> avs_waitrequest && !irq_ff && !heater_break_alarm_ff
    && !alarm1_lamp_ff && !alarm2_lamp_ff && !alarm2_contact_ff)
    else $error("outputs active in reset");
  chk_out_settle: assert property (
    ($stable(process_value) && $stable(target_setpoint) && !avs_write
    && $stable(current_loop_drive_mode)
    && $stable(heater_current_sensor))[*4]
    |=> $stable(alarm1_lamp_ff) && $stable(alarm2_lamp_ff))
    else $error("alarm toggles on steady input");
endmodule // dae_alarm_chk
bind dae_alarm dae_alarm_chk chk_i (.mclk, .nrst, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .process_value, .target_setpoint, .heater_current_sensor,
  .current_loop_drive_mode, .alarm1_lamp_ff, .alarm2_lamp_ff, .alarm2_contact_ff,
  .heater_break_alarm_ff, .irq_ff);
`default_nettype wire

// file: sim/dae_plant.sv
`timescale 1ns/1ps
`default_nettype none
module dae_plant (
  input wire logic mclk,
  input wire logic [15:0] meas_in,
  input wire logic [15:0] sp_in,
  input wire logic [5:0] cur_in,
  input wire logic mode_in,
  output logic signed [15:0] process_value,
  output logic signed [15:0] target_setpoint,
  output logic [5:0] heater_current_sensor,
  output logic current_loop_drive_mode
);
  // ********************
  // sensor front end
  // ********************
  always @(posedge mclk) begin
    process_value <= meas_in;
    target_setpoint <= sp_in;
    heater_current_sensor <= cur_in;
    current_loop_drive_mode <= mode_in;
  end
endmodule // dae_plant
`default_nettype wire

// file: sim/dual_alarm_evaluator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_alarm_evaluator_tb_top;
  logic mclk = 0, nrst = 0, avs_read = 0, avs_write = 0, md = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, q;
  logic [15:0] meas = 16'h01F4, sp = 16'h0000;
  logic [5:0] cur = 6'h14;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, l1, c1, l2, c2, hb, irq;
  wire signed [15:0] process_value, target_setpoint;
  wire [5:0] heater_current_sensor;
  wire current_loop_drive_mode;
  int error_cnt = 0, comparisons = 0, i;
  logic [15:0] meas_tab [7] = '{16'h01F4, 16'h03E9, 16'h03E6, 16'h03DE, 16'hFFCE, 16'hFFFE,
    16'h000A};
  logic [3:0] ex_tab [7] = '{4'h0, 4'hC, 4'hC, 4'h0, 4'h3, 4'h3, 4'h0};
  logic [31:0] df [8] = '{32'h1, 32'h2, 32'h5, 32'h5, 32'h3E8, 32'h0, 32'h0, 32'h1};
  logic [31:0] bd [8] = '{32'h16, 32'h15, 32'h3E9, 32'h3E9, 32'h3E9, 32'hFC17, 32'h33, 32'h33};
  initial forever #2.5 mclk = ~mclk;
  dae_plant plant (.mclk(mclk), .meas_in(meas), .sp_in(sp), .cur_in(cur), .mode_in(md),
    .process_value(process_value), .target_setpoint(target_setpoint),
    .heater_current_sensor(heater_current_sensor),
    .current_loop_drive_mode(current_loop_drive_mode));
  dae_alarm #(.ALARM2_FITTED(1)) uut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .process_value(process_value), .target_setpoint(target_setpoint),
    .heater_current_sensor(heater_current_sensor),
    .current_loop_drive_mode(current_loop_drive_mode), .alarm1_lamp_ff(l1),
    .alarm1_contact_ff(c1), .alarm2_lamp_ff(l2), .alarm2_contact_ff(c2),
    .heater_break_alarm_ff(hb), .irq_ff(irq));
  // ********************
  // bus and check tasks
  // ********************
  task bw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task br(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task go(input logic [15:0] p, input logic [5:0] c, input logic m);
    @(posedge mclk);
    meas <= p;
    cur <= c;
    md <= m;
    repeat (5) @(posedge mclk);
  endtask
  task print_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ********************
  // tests
  // ********************
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) begin
      br(i + 1, q);
      ck(q, df[i]);
      bw(i + 1, bd[i]);
      br(i + 1, q);
      ck(q, df[i]);
    end
    bw(4'hF, 32'h5);
    br(4'hF, q);
    ck(q, 32'h0);
    for (i = 0; i < 7; i++) begin
      go(meas_tab[i], 6'h14, 1'b0);
      ck({l1, c1, l2, c2}, ex_tab[i]);
    end
    bw(4'h1, 32'h9);
    go(16'h03E9, 6'h14, 1'b0);
    ck({l1, c1}, 2'h2);
    sp <= 16'h01F4;
    bw(4'h1, 32'h3);
    bw(4'h5, 32'h2BC);
    go(16'h0320, 6'h14, 1'b0);
    ck(l1, 1'b0);
    go(16'h04E2, 6'h14, 1'b0);
    ck(l1, 1'b1);
    bw(4'h1, 32'h15);
    bw(4'h7, 32'hA);
    bw(4'hB, 32'h4);
    go(16'h01F4, 6'h05, 1'b0);
    ck({l1, hb, l2, irq}, 4'hD);
    br(4'hC, q);
    ck(q, 32'h5);
    go(16'h01F4, 6'h0A, 1'b0);
    ck(hb, 1'b1);
    go(16'h01F4, 6'h0B, 1'b0);
    ck(hb, 1'b0);
    bw(4'hA, 32'h4);
    repeat (2) @(posedge mclk);
    ck(irq, 1'b0);
    go(16'h01F4, 6'h05, 1'b1);
    ck(hb, 1'b0);
    meas <= 16'hFFCE;
    nrst <= 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    bw(4'h2, 32'hC);
    go(16'hFFCE, 6'h14, 1'b0);
    ck(l2, 1'b0);
    go(16'h0032, 6'h14, 1'b0);
    go(16'hFFCE, 6'h14, 1'b0);
    ck(l2, 1'b1);
    print_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule // dual_alarm_evaluator_tb_top
`default_nettype wire
